// ### rtl/uim_pkg.sv
// Purpose: Shared constants and types of the UART interrupt enable and mask block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Each number appears here once; logic uses the names
package uim_pkg;

    localparam int          NUM_CH        = 2;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;

    // Register byte addresses
    localparam logic [7:0]  ADDR_MASK_A   = 8'h00;
    localparam logic [7:0]  ADDR_MASK_B   = 8'h04;
    localparam logic [7:0]  ADDR_CTRL     = 8'h08;
    localparam logic [7:0]  ADDR_EVT_STAT = 8'h0c;
    localparam logic [7:0]  ADDR_EVT_MASK = 8'h10;
    localparam logic [7:0]  ADDR_CHAN_STAT = 8'h14;

    // Interrupt mask register fields
    localparam int          MASK_W        = 8;
    localparam int          MASK_CTS      = 7;
    localparam int          MASK_RTS      = 6;
    localparam int          MASK_XOFF     = 5;
    localparam int          MASK_SLEEP    = 4;
    localparam int          MASK_MODEM    = 3;
    localparam int          MASK_LINE     = 2;
    localparam int          MASK_TX       = 1;
    localparam int          MASK_RX       = 0;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [7:0]  MASK_UPPER    = 8'hf0;

    // Sticky event fields, one nibble per channel
    localparam int          EVT_W         = 4;
    localparam int          EVT_CTS       = 3;
    localparam int          EVT_RTS       = 2;
    localparam int          EVT_XOFF      = 1;
    localparam int          EVT_TX        = 0;
    localparam logic [7:0]  EVT_RESET     = 8'h00;

    // Control register fields
    localparam int          CTRL_ENH_LSB  = 0;
    localparam int          CTRL_FIFO_LSB = 2;
    localparam logic [3:0]  CTRL_RESET    = 4'h0;

    // Channel status fields
    localparam int          CST_IRQ_LSB   = 0;
    localparam int          CST_SLEEP_LSB = 2;

    // Source widths
    localparam int          LINE_W        = 4;
    localparam int          MODEM_W       = 4;

    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef enum logic [1:0] {
        UIM_WR_IDLE = 2'b01,
        UIM_WR_RESP = 2'b10
    } uim_wr_state_t;

endpackage : uim_pkg

// ### rtl/uim_chan_if.sv
// Purpose: Bundle between the register top and one channel's interrupt logic
// Assumes: Single clock domain, all signals synchronous
// Notes:   Top drives configuration and sources, channel returns results
interface uim_chan_if;
    logic [7:0] mask;
    logic       fifo_mode;
    logic       rx_has_data;
    logic       rx_at_trigger;
    logic [3:0] line_err;
    logic [3:0] modem_change;
    logic       thr_empty;
    logic       tx_fifo_empty;
    logic       xoff_rx;
    logic       cts_sync;
    logic       rts_level;
    logic       isr_read;
    logic       thr_write;
    logic       irq;
    logic       sleep_en;
    logic [3:0] events;

    modport top (
        output mask,
        output fifo_mode,
        output rx_has_data,
        output rx_at_trigger,
        output line_err,
        output modem_change,
        output thr_empty,
        output tx_fifo_empty,
        output xoff_rx,
        output cts_sync,
        output rts_level,
        output isr_read,
        output thr_write,
        input  irq,
        input  sleep_en,
        input  events
    );

    modport chan (
        input  mask,
        input  fifo_mode,
        input  rx_has_data,
        input  rx_at_trigger,
        input  line_err,
        input  modem_change,
        input  thr_empty,
        input  tx_fifo_empty,
        input  xoff_rx,
        input  cts_sync,
        input  rts_level,
        input  isr_read,
        input  thr_write,
        output irq,
        output sleep_en,
        output events
    );
endinterface : uim_chan_if

// ### rtl/uim_channel.sv
// Purpose: Interrupt gating of one UART channel
// Assumes: CTS already synchronised; other sources from same-clock logic
// Notes:   Edge events latch until the source register is read, the THR is written (TX) or the mask bit clears
module uim_channel (
    input  wire logic clk,
    input  wire logic reset_n,
    uim_chan_if.chan  ch
);
    logic cts_prev_reg, cts_prev_next;
    logic rts_prev_reg, rts_prev_next;
    logic txe_prev_reg, txe_prev_next;
    logic cts_pend_reg, cts_pend_next;
    logic rts_pend_reg, rts_pend_next;
    logic xoff_pend_reg, xoff_pend_next;
    logic tx_pend_reg, tx_pend_next;
    logic irq_reg, irq_next;
    logic ev_cts, ev_rts, ev_xoff, ev_tx;
    logic rx_src, tx_src, line_src, modem_src;

    always_comb begin
        cts_prev_next = ch.cts_sync;
        rts_prev_next = ch.rts_level;
        txe_prev_next = ch.tx_fifo_empty;
        ev_cts  = ch.mask[uim_pkg::MASK_CTS] & ch.cts_sync & ~cts_prev_reg;
        ev_rts  = ch.mask[uim_pkg::MASK_RTS] & ch.rts_level & ~rts_prev_reg;
        ev_xoff = ch.mask[uim_pkg::MASK_XOFF] & ch.xoff_rx;
        ev_tx   = ch.mask[uim_pkg::MASK_TX] & ch.fifo_mode & ch.tx_fifo_empty & ~txe_prev_reg;
        // New event beats a read in the same cycle
        cts_pend_next  = ev_cts | (cts_pend_reg & ~ch.isr_read & ch.mask[uim_pkg::MASK_CTS]);
        rts_pend_next  = ev_rts | (rts_pend_reg & ~ch.isr_read & ch.mask[uim_pkg::MASK_RTS]);
        xoff_pend_next = ev_xoff | (xoff_pend_reg & ~ch.isr_read & ch.mask[uim_pkg::MASK_XOFF]);
        tx_pend_next   = ev_tx | (tx_pend_reg & ~(ch.isr_read | ch.thr_write)
                         & ch.mask[uim_pkg::MASK_TX] & ch.fifo_mode);
        rx_src    = ch.fifo_mode ? ch.rx_at_trigger : ch.rx_has_data;
        tx_src    = ch.fifo_mode ? tx_pend_reg
                                 : (ch.thr_empty & ch.mask[uim_pkg::MASK_TX]);
        line_src  = ch.mask[uim_pkg::MASK_LINE] & (|ch.line_err);
        modem_src = ch.mask[uim_pkg::MASK_MODEM] & (|ch.modem_change);
        irq_next  = (rx_src & ch.mask[uim_pkg::MASK_RX]) | tx_src | line_src | modem_src
                    | cts_pend_reg | rts_pend_reg | xoff_pend_reg;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cts_prev_reg  <= 1'b0;
            rts_prev_reg  <= 1'b0;
            txe_prev_reg  <= 1'b0;
            cts_pend_reg  <= 1'b0;
            rts_pend_reg  <= 1'b0;
            xoff_pend_reg <= 1'b0;
            tx_pend_reg   <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            cts_prev_reg  <= cts_prev_next;
            rts_prev_reg  <= rts_prev_next;
            txe_prev_reg  <= txe_prev_next;
            cts_pend_reg  <= cts_pend_next;
            rts_pend_reg  <= rts_pend_next;
            xoff_pend_reg <= xoff_pend_next;
            tx_pend_reg   <= tx_pend_next;
            irq_reg       <= irq_next;
        end
    end

    assign ch.irq      = irq_reg;
    assign ch.sleep_en = ch.mask[uim_pkg::MASK_SLEEP];
    assign ch.events   = {ev_cts, ev_rts, ev_xoff, ev_tx};

endmodule : uim_channel

// ### rtl/uim_irq_enable_mask.sv
// Purpose: Dual-channel UART interrupt enable and mask, AXI4-Lite slave
// Assumes: UART sources on this clock except the CTS pins
// Notes:   One write and one read in flight; unmapped addresses answer SLVERR
//
// Chosen here: the AXI4-Lite register port and the address map.
module uim_irq_enable_mask (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic [uim_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [uim_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [uim_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [uim_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [1:0]                    clear_to_send_inputs,
    input  wire logic [1:0]                    request_to_send_outputs,
    input  wire logic [1:0]                    rx_data_flag,
    input  wire logic [1:0]                    rx_trigger_reached,
    input  wire logic [7:0]                    line_state_errors,
    input  wire logic [7:0]                    modem_state_changes,
    input  wire logic [1:0]                    tx_holding_empty,
    input  wire logic [1:0]                    tx_fifo_empty,
    input  wire logic [1:0]                    xoff_received,
    input  wire logic [1:0]                    isr_read_strobe,
    input  wire logic [1:0]                    thr_write_strobe,
    output logic                               channel_a_irq_out,
    output logic                               channel_b_irq_out,
    output logic [1:0]                         sleep_enable,
    output logic                               event_irq
);
    localparam int NC = uim_pkg::NUM_CH;

    uim_pkg::uim_wr_state_t          wr_state_reg, wr_state_next;
    logic                            aw_got_reg, aw_got_next;
    logic                            w_got_reg, w_got_next;
    logic [uim_pkg::ADDR_W-1:0]      waddr_reg, waddr_next;
    logic [uim_pkg::DATA_W-1:0]      wdata_reg, wdata_next;
    logic                            wstrb0_reg, wstrb0_next;
    logic [1:0]                      bresp_reg, bresp_next;
    logic                            rvalid_reg, rvalid_next;
    logic [uim_pkg::DATA_W-1:0]      rdata_reg, rdata_next;
    logic [1:0]                      rresp_reg, rresp_next;

    logic [uim_pkg::MASK_W-1:0]      mask_reg [NC];
    logic [uim_pkg::MASK_W-1:0]      mask_next [NC];
    logic [3:0]                      ctrl_reg, ctrl_next;
    logic [NC*uim_pkg::EVT_W-1:0]    evt_stat_reg, evt_stat_next;
    logic [NC*uim_pkg::EVT_W-1:0]    evt_mask_reg, evt_mask_next;
    logic [NC-1:0]                   cts_meta_reg, cts_meta_next;
    logic [NC-1:0]                   cts_sync_reg, cts_sync_next;

    logic [NC-1:0]                   chan_irq;
    logic [NC-1:0]                   chan_sleep;
    logic [NC*uim_pkg::EVT_W-1:0]    chan_events;
    logic                            do_write;
    logic [uim_pkg::DATA_W-1:0]      rd_value;
    logic                            rd_hit;
    logic                            wr_hit;
    logic [uim_pkg::EVT_W*NC-1:0]    w1c;

    // Decode shared by both read and write paths
    function automatic logic addr_mapped(input logic [uim_pkg::ADDR_W-1:0] a);
        addr_mapped = (a == uim_pkg::ADDR_MASK_A) || (a == uim_pkg::ADDR_MASK_B)
                   || (a == uim_pkg::ADDR_CTRL) || (a == uim_pkg::ADDR_EVT_STAT)
                   || (a == uim_pkg::ADDR_EVT_MASK) || (a == uim_pkg::ADDR_CHAN_STAT);
    endfunction : addr_mapped

    // Apply a mask write, upper half held unless enhanced functions are on
    function automatic logic [7:0] mask_write(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic enh);
        logic [7:0] keep;
        keep = enh ? 8'h00 : uim_pkg::MASK_UPPER;
        mask_write = (old_v & keep) | (new_v & ~keep);
    endfunction : mask_write

    // Write channel: address and data taken in any order
    assign s_axi_awready = (wr_state_reg == uim_pkg::UIM_WR_IDLE) && !aw_got_reg;
    assign s_axi_wready  = (wr_state_reg == uim_pkg::UIM_WR_IDLE) && !w_got_reg;
    assign s_axi_bvalid  = (wr_state_reg == uim_pkg::UIM_WR_RESP);
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_comb begin
        wr_state_next = wr_state_reg;
        aw_got_next   = aw_got_reg;
        w_got_next    = w_got_reg;
        waddr_next    = waddr_reg;
        wdata_next    = wdata_reg;
        wstrb0_next   = wstrb0_reg;
        bresp_next    = bresp_reg;
        do_write      = 1'b0;
        wr_hit        = addr_mapped(waddr_reg);
        case (wr_state_reg)
            uim_pkg::UIM_WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got_next = 1'b1;
                    waddr_next  = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got_next  = 1'b1;
                    wdata_next  = s_axi_wdata;
                    wstrb0_next = s_axi_wstrb[0];
                end
                if (aw_got_reg && w_got_reg) begin
                    do_write      = 1'b1;
                    bresp_next    = wr_hit ? uim_pkg::RESP_OKAY : uim_pkg::RESP_SLVERR;
                    aw_got_next   = 1'b0;
                    w_got_next    = 1'b0;
                    wr_state_next = uim_pkg::UIM_WR_RESP;
                end
            end
            uim_pkg::UIM_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_next = uim_pkg::UIM_WR_IDLE;
                end
            end
            default: begin
                wr_state_next = uim_pkg::UIM_WR_IDLE;
            end
        endcase
    end

    // Register file next values
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            mask_next[i] = mask_reg[i];
        end
        ctrl_next     = ctrl_reg;
        evt_mask_next = evt_mask_reg;
        w1c           = '0;
        // Only the low byte lane carries register bits
        if (do_write && wstrb0_reg) begin
            case (waddr_reg)
                uim_pkg::ADDR_MASK_A: begin
                    mask_next[0] = mask_write(mask_reg[0], wdata_reg[7:0],
                                              ctrl_reg[uim_pkg::CTRL_ENH_LSB]);
                end
                uim_pkg::ADDR_MASK_B: begin
                    mask_next[1] = mask_write(mask_reg[1], wdata_reg[7:0],
                                              ctrl_reg[uim_pkg::CTRL_ENH_LSB+1]);
                end
                uim_pkg::ADDR_CTRL: begin
                    ctrl_next = wdata_reg[3:0];
                end
                uim_pkg::ADDR_EVT_STAT: begin
                    w1c = wdata_reg[7:0];
                end
                uim_pkg::ADDR_EVT_MASK: begin
                    evt_mask_next = wdata_reg[7:0];
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        evt_stat_next = (evt_stat_reg & ~w1c) | chan_events;
        cts_meta_next = clear_to_send_inputs;
        cts_sync_next = cts_meta_reg;
    end

    // Read channel
    always_comb begin
        rd_value = '0;
        rd_hit   = addr_mapped(s_axi_araddr);
        case (s_axi_araddr)
            uim_pkg::ADDR_MASK_A:    rd_value[7:0] = mask_reg[0];
            uim_pkg::ADDR_MASK_B:    rd_value[7:0] = mask_reg[1];
            uim_pkg::ADDR_CTRL:      rd_value[3:0] = ctrl_reg;
            uim_pkg::ADDR_EVT_STAT:  rd_value[7:0] = evt_stat_reg;
            uim_pkg::ADDR_EVT_MASK:  rd_value[7:0] = evt_mask_reg;
            uim_pkg::ADDR_CHAN_STAT: rd_value[3:0] = {chan_sleep, chan_irq};
            default:                 rd_value      = '0;
        endcase
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_next = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_value;
            rresp_next  = rd_hit ? uim_pkg::RESP_OKAY : uim_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_state_reg <= uim_pkg::UIM_WR_IDLE;
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            waddr_reg    <= '0;
            wdata_reg    <= '0;
            wstrb0_reg   <= 1'b0;
            bresp_reg    <= uim_pkg::RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= '0;
            rresp_reg    <= uim_pkg::RESP_OKAY;
            for (int i = 0; i < NC; i++) begin
                mask_reg[i] <= uim_pkg::MASK_RESET;
            end
            ctrl_reg     <= uim_pkg::CTRL_RESET;
            evt_stat_reg <= uim_pkg::EVT_RESET;
            evt_mask_reg <= uim_pkg::EVT_RESET;
            cts_meta_reg <= '0;
            cts_sync_reg <= '0;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_got_reg   <= aw_got_next;
            w_got_reg    <= w_got_next;
            waddr_reg    <= waddr_next;
            wdata_reg    <= wdata_next;
            wstrb0_reg   <= wstrb0_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
            for (int i = 0; i < NC; i++) begin
                mask_reg[i] <= mask_next[i];
            end
            ctrl_reg     <= ctrl_next;
            evt_stat_reg <= evt_stat_next;
            evt_mask_reg <= evt_mask_next;
            cts_meta_reg <= cts_meta_next;
            cts_sync_reg <= cts_sync_next;
        end
    end

    // One independent gating instance per channel
    generate
        for (genvar c = 0; c < NC; c++) begin : g_chan
            uim_chan_if ifc ();

            assign ifc.mask          = mask_reg[c];
            assign ifc.fifo_mode     = ctrl_reg[uim_pkg::CTRL_FIFO_LSB+c];
            assign ifc.rx_has_data   = rx_data_flag[c];
            assign ifc.rx_at_trigger = rx_trigger_reached[c];
            assign ifc.line_err      = line_state_errors[c*uim_pkg::LINE_W +: uim_pkg::LINE_W];
            assign ifc.modem_change  = modem_state_changes[c*uim_pkg::MODEM_W +: uim_pkg::MODEM_W];
            assign ifc.thr_empty     = tx_holding_empty[c];
            assign ifc.tx_fifo_empty = tx_fifo_empty[c];
            assign ifc.xoff_rx       = xoff_received[c];
            assign ifc.cts_sync      = cts_sync_reg[c];
            assign ifc.rts_level     = request_to_send_outputs[c];
            assign ifc.isr_read      = isr_read_strobe[c];
            assign ifc.thr_write     = thr_write_strobe[c];
            assign chan_irq[c]       = ifc.irq;
            assign chan_sleep[c]     = ifc.sleep_en;
            assign chan_events[c*uim_pkg::EVT_W +: uim_pkg::EVT_W] = ifc.events;

            uim_channel u_chan (
                .clk     (clk),
                .reset_n (reset_n),
                .ch      (ifc)
            );
        end
    endgenerate

    assign channel_a_irq_out = chan_irq[0];
    assign channel_b_irq_out = chan_irq[1];
    assign sleep_enable      = chan_sleep;
    // Summary interrupt for software polling of edge events
    assign event_irq         = |(evt_stat_reg & evt_mask_reg);

endmodule : uim_irq_enable_mask

// ### testbench/uim_irq_properties.sv
// Purpose: Port checks
// Assumes: One clock
// Notes:   Bind below
module uim_irq_checker (
    input logic        clk,
    input logic        reset_n,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic [1:0]  rx_data_flag,
    input logic        channel_a_irq_out,
    input logic        channel_b_irq_out,
    input logic [1:0]  sleep_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    reset_clear_a: assert property ($rose(reset_n) |-> !channel_a_irq_out && !channel_b_irq_out && !sleep_enable)
        else $error("outputs set after reset");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write resp late");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken busy");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken busy");
    sleep_still_a: assert property (!$rose(s_axi_bvalid) |-> $stable(sleep_enable))
        else $error("sleep changed without write");
    sleep_set_a: assert property ($rose(sleep_enable[0]) |-> $past(s_axi_wdata[4], 2))
        else $error("sleep set without bit 4");
    irq_b_cause_a: assert property ($rose(channel_b_irq_out) |-> $past(rx_data_flag[1]))
        else $error("irq b uncaused");
    cover property ($rose(channel_a_irq_out));
    cover property ($rose(channel_b_irq_out));
    cover property ($rose(sleep_enable[0]));
endmodule : uim_irq_checker

bind uim_irq_enable_mask uim_irq_checker uim_irq_checker_inst (.*);

// ### testbench/uim_cts_model.sv
// Purpose: CTS pin model
// Assumes: Async to clk
// Notes:   Fixed delay
module uim_cts_model #(parameter time DLY = 3ns) (
    input  wire logic [1:0] go,
    output logic      [1:0] cts
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cts = 2'b00;
    always @(go) cts <= #DLY go;
endmodule : uim_cts_model

// ### testbench/uim_irq_enable_mask_tb.sv
// Purpose: Mask block bench
// Assumes: 100 MHz clock
// Notes:   Queued bus checks
module uim_irq_enable_mask_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MA = uim_pkg::ADDR_MASK_A, MC = uim_pkg::ADDR_CTRL, ES = uim_pkg::ADDR_EVT_STAT;
    logic clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, event_irq;
    logic channel_a_irq_out, channel_b_irq_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, line_state_errors, modem_state_changes;
    logic [31:0] s_axi_wdata, s_axi_rdata, r, seed = 32'h0001128f;
    logic [3:0]  s_axi_wstrb, v;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sleep_enable, clear_to_send_inputs, request_to_send_outputs, cts_go;
    logic [1:0]  rx_data_flag, rx_trigger_reached, tx_holding_empty, tx_fifo_empty;
    logic [1:0]  xoff_received, isr_read_strobe, thr_write_strobe;
    logic [33:0] rq[$], bq[$];
    int fail_count, tests_run;

    uim_irq_enable_mask uim_irq_enable_mask_inst (.*);
    uim_cts_model uim_cts_model_inst (.go(cts_go), .cts(clear_to_send_inputs));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic ca(input logic e);
        chk("irq_a", 34'(e), channel_a_irq_out);
    endtask : ca

    task automatic wrap_up();
        $display("checks %0d fails %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Both halves offered at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs = uim_pkg::RESP_OKAY);
        bq.push_back({rs, 32'h0});
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= (xs() << 8) | 32'(d);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wstrb} <= 7'h7f;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), {s_axi_bresp, 32'h0});
    end

    initial begin
        #50us;
        fail_count++;
        wrap_up();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cts_go} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, request_to_send_outputs} = '0;
        {rx_data_flag, rx_trigger_reached, tx_holding_empty, tx_fifo_empty, xoff_received} = '0;
        {isr_read_strobe, thr_write_strobe, line_state_errors, modem_state_changes} = '0;
        reset_n = 1'b0;
        tick(6);
        reset_n <= 1'b1;
        for (int a = 0; a < 8'h1c; a += 4) rd(8'(a), a < 8'h18 ? 34'h0 : {uim_pkg::RESP_SLVERR, 32'h0});
        wr(8'h18, 8'h00, uim_pkg::RESP_SLVERR);
        $display("test reset done");
        wr(MA, 8'hff);
        rd(MA, 34'h0f);
        chk("sleep", 34'h0, sleep_enable);
        wr(MC, 8'h01);
        wr(MA, 8'hff);
        rd(MA, 34'hff);
        chk("sleep", 34'h1, sleep_enable);
        rx_data_flag <= 2'b10;
        wr(uim_pkg::ADDR_MASK_B, 8'h01);
        tick(2);
        chk("irq_b", 34'h1, channel_b_irq_out);
        ca(0);
        $display("test enable done");
        // Others on first so a stray gate shows
        for (int i = 0; i < 4; i++) begin
            wr(MA, 8'(1 << i));
            for (int e = 0; e < 2; e++) begin
                v = e ? 4'hf : ~(4'h1 << i);
                r = xs();
                rx_data_flag <= {1'b0, v[0]};
                tx_holding_empty <= {1'b0, v[1]};
                line_state_errors <= {r[7:4], v[2] ? r[3:0] | 4'h1 : 4'h0};
                modem_state_changes <= {r[15:12], v[3] ? r[11:8] | 4'h1 : 4'h0};
                tick(3);
                ca(e[0]);
            end
        end
        {rx_data_flag, tx_holding_empty, line_state_errors, modem_state_changes} <= '0;
        $display("test level done");
        wr(MC, 8'h05);
        wr(MA, 8'h01);
        for (int k = 0; k < 3; k++) begin
            rx_data_flag <= 2'b01;
            rx_trigger_reached <= {1'b0, k[0]};
            tick(3);
            ca(k[0]);
        end
        rx_data_flag <= 2'b00;
        wr(MA, 8'h02);
        for (int k = 0; k < 2; k++) begin
            tx_fifo_empty <= 2'b01;
            tick(3);
            ca(1);
            if (k) isr_read_strobe <= 2'b01;
            else thr_write_strobe <= 2'b01;
            tick(1);
            {isr_read_strobe, thr_write_strobe} <= '0;
            tick(3);
            ca(0);
            tx_fifo_empty <= 2'b00;
            tick(2);
        end
        $display("test fifo done");
        for (int k = 0; k < 3; k++) begin
            for (int e = 0; e < 2; e++) begin
                wr(MA, e ? 8'h20 << k : 8'h00);
                case (k)
                    0: xoff_received <= 2'b01;
                    1: request_to_send_outputs <= 2'b01;
                    default: cts_go <= 2'b01;
                endcase
                tick(1);
                xoff_received <= 2'b00;
                tick(6);
                ca(e[0]);
                isr_read_strobe <= 2'b01;
                tick(1);
                {isr_read_strobe, request_to_send_outputs, cts_go} <= '0;
                tick(6);
                ca(0);
            end
        end
        $display("test edge done");
        rd(ES, 34'h0f);
        chk("event_irq", 34'h0, event_irq);
        wr(uim_pkg::ADDR_EVT_MASK, 8'h0f);
        tick(1);
        chk("event_irq", 34'h1, event_irq);
        wr(ES, 8'h0f);
        tick(1);
        chk("event_irq", 34'h0, event_irq);
        rd(ES, 34'h00);
        $display("test event done");
        wrap_up();
    end
endmodule : uim_irq_enable_mask_tb
